// *** rtl/borl_relay.sv ***
`timescale 1ns/1ps
module borl_relay
	import borl_pkg::*;
#(
	parameter int N_ASSIGN   = NUM_ASSIGN,
	parameter int LIST_WIDTH = LIST_W,
	parameter int SEL_WIDTH  = SEL_W,
	parameter int TICK_CYC   = STEP_CYCLES
) (
	input  wire logic                                clk,
	input  wire logic                                rst_b,
	input  wire logic [LIST_WIDTH-1:0]               sig_list,
	input  wire logic [N_ASSIGN-1:0]                 assign_en,
	input  wire logic [N_ASSIGN-1:0][SEL_WIDTH-1:0]  assign_sel,
	input  wire logic [N_ASSIGN-1:0]                 sig_invert,
	input  wire logic                                out_invert,
	input  wire logic                                latch_en,
	input  wire logic                                ack_en,
	input  wire logic [SEL_WIDTH-1:0]                ack_sel,
	input  wire logic [TIME_W-1:0]                   hold_time,
	input  wire logic [TIME_W-1:0]                   off_delay,
	output logic                                     relay_out,
	output logic                                     relay_state,
	output logic                                     latched,
	output logic                                     ack_setting_avail,
	output logic                                     hold_active,
	output logic                                     off_delay_active
);

	////////////////////////////////////////////////////////////////////////
	// Functions

	// Pick one entry of the assignment list, zero when out of range
	function automatic logic pick(
		input logic [LIST_WIDTH-1:0] list,
		input logic [SEL_WIDTH-1:0]  idx
	);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < LIST_WIDTH; i++) begin
			if (idx == SEL_WIDTH'(i))
				hit = list[i];
		end
		return hit;
	endfunction

	// Steps to tick counts; one extra tick covers prescaler phase
	function automatic logic [TIME_W-1:0] steps(
		input logic [TIME_W-1:0] setting
	);
		logic [TIME_W-1:0] clamped;
		clamped = (setting > TIME_MAX) ? TIME_MAX : setting;
		if (clamped == TIME_ZERO)
			return TIME_ZERO;
		return clamped + TIME_ONE;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Step tick prescaler

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);

	logic [TICK_W-1:0] presc;
	logic [TICK_W-1:0] next_presc;
	logic              tick;
	wire               presc_wrap = (presc == TICK_LAST);

	assign next_presc = presc_wrap ? '0 : presc + TICK_W'(1);

	always_ff @(posedge clk) begin
		if (!rst_b)
			presc <= '0;
		else
			presc <= next_presc;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			tick <= 1'b0;
		else
			tick <= presc_wrap;
	end

	////////////////////////////////////////////////////////////////////////
	// Assigned signal combination

	logic [N_ASSIGN-1:0] slot_val;
	logic                drive;

	genvar g;
	generate
		for (g = 0; g < N_ASSIGN; g++) begin : gen_slot
			// Unassigned slot contributes nothing
			assign slot_val[g] = assign_en[g]
				& (pick(sig_list, assign_sel[g]) ^ sig_invert[g]);
		end
	endgenerate

	assign drive = |slot_val;

	////////////////////////////////////////////////////////////////////////
	// Acknowledge and latching

	wire ack_raw = ack_en & pick(sig_list, ack_sel);
	wire ack_eff = ack_raw & latch_en;

	borl_state_t state;
	borl_state_t next_state;

	always_comb begin
		next_state = state;
		case (state)
			BORL_OFF: begin
				if (drive)
					next_state = BORL_ON;
			end
			BORL_ON: begin
				if (!drive)
					next_state = BORL_OFF;
				else if (latch_en)
					next_state = BORL_LATCHED;
			end
			BORL_LATCHED: begin
				// Pending pickup beats acknowledge
				if (!latch_en)
					next_state = drive ? BORL_ON : BORL_OFF;
				else if (ack_eff && !drive)
					next_state = BORL_OFF;
			end
			default: begin
				next_state = BORL_OFF;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			state <= BORL_OFF;
		else
			state <= next_state;
	end

	wire demand = drive | (state == BORL_LATCHED);

	////////////////////////////////////////////////////////////////////////
	// Switch-off delay

	logic off_busy;

	borl_timer #(
		.W        (TIME_W)
	) u_off_timer (
		.clk      (clk),
		.rst_b    (rst_b),
		.load     (demand),
		.load_val (steps(off_delay)),
		.tick     (tick),
		.busy     (off_busy)
	);

	wire request = demand | off_busy;

	////////////////////////////////////////////////////////////////////////
	// Minimum hold of each new state

	logic hold_busy;
	logic relay_int;
	logic next_relay_int;
	wire  change = (request != relay_int) & ~hold_busy;

	assign next_relay_int = change ? request : relay_int;

	borl_timer #(
		.W        (TIME_W)
	) u_hold_timer (
		.clk      (clk),
		.rst_b    (rst_b),
		.load     (change),
		.load_val (steps(hold_time)),
		.tick     (tick),
		.busy     (hold_busy)
	);

	always_ff @(posedge clk) begin
		if (!rst_b)
			relay_int <= RST_RELAY;
		else
			relay_int <= next_relay_int;
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs

	always_ff @(posedge clk) begin
		if (!rst_b)
			relay_out <= RST_RELAY;
		else
			relay_out <= next_relay_int ^ out_invert;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			relay_state <= RST_RELAY;
		else
			relay_state <= next_relay_int;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			latched <= RST_LATCH;
		else
			latched <= (next_state == BORL_LATCHED);
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			ack_setting_avail <= 1'b0;
		else
			ack_setting_avail <= latch_en;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			hold_active <= 1'b0;
		else
			hold_active <= hold_busy | change;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			off_delay_active <= 1'b0;
		else
			off_delay_active <= off_busy & ~demand;
	end

endmodule

// *** shared/borl_pkg.sv ***
package borl_pkg;

	// Assignment structure
	localparam int NUM_ASSIGN = 7;
	localparam int LIST_W     = 32;
	localparam int SEL_W      = 5;

	// Time settings, counted in 10 ms steps
	localparam int        TIME_W      = 16;
	localparam int        STEP_MS     = 10;
	localparam int        CLK_NS      = 40;
	localparam int        STEP_CYCLES = (STEP_MS * 1000000) / CLK_NS;
	localparam int        TICK_W      = 20;
	localparam [15:0]     TIME_MAX    = 16'h7530;
	localparam [15:0]     TIME_ZERO   = 16'h0000;
	localparam [15:0]     TIME_ONE    = 16'h0001;

	// Reset values
	localparam logic      RST_RELAY   = 1'b0;
	localparam logic      RST_LATCH   = 1'b0;

	// Relay state machine
	typedef enum logic [1:0] {
		BORL_OFF,
		BORL_ON,
		BORL_LATCHED
	} borl_state_t;

endpackage

// *** rtl/borl_timer.sv ***
`timescale 1ns/1ps
module borl_timer
	import borl_pkg::*;
#(
	parameter int W = TIME_W
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	input  wire logic         tick,
	output logic              busy
);

	logic [W-1:0] count;
	logic [W-1:0] next_count;
	wire          nonzero = (count != '0);

	////////////////////////////////////////////////////////////////////////
	// Countdown in step ticks
	assign next_count = load ? load_val
		: (tick && nonzero) ? count - W'(1) : count;
	assign busy = nonzero;

	always_ff @(posedge clk) begin
		if (!rst_b)
			count <= '0;
		else
			count <= next_count;
	end

endmodule

// *** bench/borl_relay_monitor.sv ***
`timescale 1ns/1ps
module borl_relay_monitor
	import borl_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_b,
	input wire logic [LIST_W-1:0] sig_list,
	input wire logic              out_invert,
	input wire logic              latch_en,
	input wire logic              ack_en,
	input wire logic [SEL_W-1:0]  ack_sel,
	input wire logic [TIME_W-1:0] hold_time,
	input wire logic [TIME_W-1:0] off_delay,
	input wire logic              relay_out,
	input wire logic              relay_state,
	input wire logic              latched,
	input wire logic              ack_setting_avail,
	input wire logic              hold_active,
	input wire logic              off_delay_active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire ack_seen = ack_en & sig_list[ack_sel];
	////////////////////////////////////////////////////////////////
	out_inv_a: assert property (
		relay_out == (relay_state ^ $past(out_invert)))
		else $error("relay output polarity wrong");
	ack_avail_a: assert property (
		ack_setting_avail == $past(latch_en))
		else $error("ack setting offer wrong");
	latch_rise_a: assert property (
		$rose(latched) && !hold_active |-> $past(latch_en) && relay_state)
		else $error("latch set without cause");
	latch_keep_a: assert property (
		latched && latch_en && !ack_seen |=> latched)
		else $error("latch lost without ack");
	ack_free_a: assert property (
		!$past(latch_en) |-> !latched)
		else $error("latched while latching off");
	latch_on_a: assert property (
		latched && !hold_active |-> relay_state)
		else $error("latched but relay off");
	hold_min_a: assert property (
		$changed(relay_state) && $past(hold_time) == 16'h0002
		|=> $stable(relay_state)[*7])
		else $error("state not held");
	hold_flag_a: assert property (
		$changed(relay_state) && hold_time != 16'h0000 |-> hold_active)
		else $error("hold flag missing");
	off_min_a: assert property (
		$fell(relay_state) && off_delay == 16'h0002
		|-> $past(off_delay_active, 7))
		else $error("off delay too short");
	off_max_a: assert property (
		$rose(off_delay_active) && off_delay == 16'h0002
		|-> ##[1:14] !off_delay_active)
		else $error("off delay too long");
	cover property ($rose(latched));
	cover property ($rose(hold_active));
	cover property ($fell(off_delay_active));
endmodule

// *** bench/borl_switchgear.sv ***
`timescale 1ns/1ps
module borl_switchgear (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic coil,
	output logic      closed
);
	// Contacts follow the coil one cycle late
	always_ff @(posedge clk) begin
		closed <= rst_b & coil;
	end
endmodule

// *** bench/tb_borl_relay.sv ***
`timescale 1ns/1ps
module tb_borl_relay;
	import borl_pkg::*;
	logic            clk = 0, rst_b = 0, out_invert = 0;
	logic            latch_en = 0, ack_en = 0;
	logic [31:0]     sig_list = '0;
	logic [6:0]      assign_en = '0, sig_invert = '0;
	logic [6:0][4:0] assign_sel = '0;
	logic [4:0]      ack_sel = '0;
	logic [15:0]     hold_time = '0, off_delay = '0;
	logic            relay_out, relay_state, latched, closed;
	logic            ack_setting_avail, hold_active, off_delay_active;
	int              fails = 0, cmp_count = 0, cyc = 0;
	borl_relay #(.TICK_CYC(4)) borl_relay_inst (
		.clk               (clk),
		.rst_b             (rst_b),
		.sig_list          (sig_list),
		.assign_en         (assign_en),
		.assign_sel        (assign_sel),
		.sig_invert        (sig_invert),
		.out_invert        (out_invert),
		.latch_en          (latch_en),
		.ack_en            (ack_en),
		.ack_sel           (ack_sel),
		.hold_time         (hold_time),
		.off_delay         (off_delay),
		.relay_out         (relay_out),
		.relay_state       (relay_state),
		.latched           (latched),
		.ack_setting_avail (ack_setting_avail),
		.hold_active       (hold_active),
		.off_delay_active  (off_delay_active)
	);
	borl_switchgear borl_switchgear_inst (.clk, .rst_b, .coil(relay_out),
		.closed);
	always #20 clk = ~clk;
	////////////////////////////////////////////////////////////////
	task chk(input logic seen, input logic exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task go(input int n);
		repeat (n) @(posedge clk);
	endtask
	task results;
		$display("Checks %0d errors %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		go(20);
		rst_b <= 1;
		go(3);
		chk(relay_out, 1'b0);
		for (int g = 0; g < 7; g++) begin
			assign_en <= 7'(1 << g);
			assign_sel[g] <= 5'(g + 8);
			sig_invert <= '0;
			sig_list <= 32'h1 << (g + 8);
			go(3);
			chk(relay_state, 1'b1);
			sig_invert <= 7'(1 << g);
			go(3);
			chk(relay_state, 1'b0);
		end
		out_invert <= 1;
		go(3);
		chk(relay_out, 1'b1);
		chk(closed, 1'b1);
		out_invert <= 0;
		latch_en <= 1;
		ack_en <= 1;
		ack_sel <= 5'h02;
		sig_invert <= '0;
		sig_list <= '0;
		go(2);
		chk(ack_setting_avail, 1'b1);
		sig_list <= 32'h4004;
		go(4);
		chk(latched, 1'b1);
		sig_list <= '0;
		go(4);
		chk(relay_state, 1'b1);
		sig_list <= 32'h4;
		go(3);
		chk(latched, 1'b0);
		chk(relay_state, 1'b0);
		latch_en <= 0;
		sig_list <= 32'h4004;
		go(3);
		chk(relay_state, 1'b1);
		chk(ack_setting_avail, 1'b0);
		sig_list <= '0;
		go(3);
		chk(latched, 1'b0);
		chk(relay_state, 1'b0);
		hold_time <= 16'h0002;
		sig_list <= 32'h4000;
		go(2);
		sig_list <= '0;
		go(4);
		chk(relay_state, 1'b1);
		chk(hold_active, 1'b1);
		go(14);
		chk(relay_state, 1'b0);
		hold_time <= '0;
		go(12);
		off_delay <= 16'h0002;
		sig_list <= 32'h4000;
		go(3);
		sig_list <= '0;
		go(6);
		chk(relay_state, 1'b1);
		chk(off_delay_active, 1'b1);
		go(12);
		chk(relay_state, 1'b0);
		results();
	end
endmodule
bind borl_relay borl_relay_monitor borl_relay_monitor_inst (.clk, .rst_b,
	.sig_list, .out_invert, .latch_en, .ack_en, .ack_sel, .hold_time,
	.off_delay, .relay_out, .relay_state, .latched, .ack_setting_avail,
	.hold_active, .off_delay_active);
